// File: rtl/pgc_cfg.svh
`ifndef PGC_CFG_SVH
`define PGC_CFG_SVH

// Datapath and bus widths
`define PGC_DW 32
`define PGC_ADR_W 10
`define PGC_SEED_W 58

// Register indices; byte address is four times the index
`define PGC_IDX_SEED_A0 10'h12d
`define PGC_IDX_SEED_A1 10'h12e
`define PGC_IDX_SEED_A2 10'h12f
`define PGC_IDX_SEED_A3 10'h130
`define PGC_IDX_SEED_B0 10'h131
`define PGC_IDX_SEED_B1 10'h132
`define PGC_IDX_SEED_B2 10'h133
`define PGC_IDX_SEED_B3 10'h134
`define PGC_IDX_TX_CTRL 10'h135
`define PGC_IDX_TX_GATE 10'h137
`define PGC_IDX_RX_CTRL 10'h15e
`define PGC_IDX_RX_GATE 10'h164
`define PGC_IDX_RX_KIND 10'h169

// Field positions, transmit control
`define PGC_TX_SQW_MSB 15
`define PGC_TX_SQW_LSB 12
`define PGC_TX_P7_BIT 10
`define PGC_TX_P23_BIT 8
`define PGC_TX_P9_BIT 6
`define PGC_TX_P31_BIT 4
`define PGC_TX_TEST_BIT 3
`define PGC_TX_PSEL_BIT 1
`define PGC_TX_DSEL_BIT 0
// Field positions, transmit clock gates
`define PGC_TX_PRBS_CE_BIT 2
`define PGC_TX_SQW_CE_BIT 1
// Field positions, receive control and gates
`define PGC_RX_P7_BIT 14
`define PGC_RX_P23_BIT 13
`define PGC_RX_P9_BIT 12
`define PGC_RX_P31_BIT 11
`define PGC_RX_TEST_BIT 10
`define PGC_RX_CE_BIT 10
`define PGC_RX_KIND_BIT 0

// Reset values
`define PGC_RST_SEED_A 58'h2aa_aaaa_aaaa_aaaa
`define PGC_RST_SEED_B 58'h155_5555_5555_5555
`define PGC_RST_SQW 4'h4

// Pattern constants
`define PGC_LF_WORD 32'h0100_009c
`define PGC_LOCK_WORDS 5'h10
`define PGC_RESEED_CNT_W 7
`define PGC_SCR_TAP_A 38
`define PGC_SCR_TAP_B 57

`endif

// File: rtl/pgc_pkg.sv
`include "pgc_cfg.svh"

package pgc_pkg;

  // Classic Wishbone request from the master
  typedef struct packed {
    logic cyc;
    logic stb;
    logic we;
    logic [3:0] sel;
    logic [`PGC_ADR_W-1:0] adr;
    logic [`PGC_DW-1:0] dat;
  } pgc_wb_req_t;

  // Polynomial chosen by the one-hot enables
  typedef enum logic [2:0] {
    POLY_NONE,
    POLY_7,
    POLY_9,
    POLY_23,
    POLY_31
  } pgc_poly_t;

  // Verifier lock state
  typedef enum logic {
    CHK_HUNT,
    CHK_LOCKED
  } pgc_chk_state_t;

endpackage : pgc_pkg

// File: rtl/pgc_top.sv
`timescale 1ns/1ps
`include "pgc_cfg.svh"

// Notes on behaviour
// - Test-enable bits start generator and verifier
// - PRBS inverted on send and before checking
// - Seed A, 58 bits over four registers
// - Seed B, 58 bits over four registers
// - Square wave run length 1,4,5,6,8,10
// - Transmit bits 10/8/6/4 pick PRBS polynomial
// - Pattern select one: square, zero: random
// - Data select: local faults or zeros
// - Transmit PRBS and square clock enables
// - Receive bits 14..11 pick polynomial, 10 enables
// - Receive PRBS clock enable gates verifier
// - Receive select one: square mode
// - PRBS polynomials 7, 9, 23, 31
// - Pseudo-random pattern needs no clock enable
// - No square-wave checker on receive
// - Lock, mismatch outputs and mismatch clear
// - Unassigned bits reserved, no effect
module pgc_top (
  // Clock, reset, enable
  input wire logic CORE_CLK_IN,
  input wire logic RESET_IN,
  input wire logic CLK_EN_IN,
  // Wishbone slave
  input wire pgc_pkg::pgc_wb_req_t WB_REQ_IN,
  output logic [`PGC_DW-1:0] WB_DAT_OUT,
  output logic WB_ACK_OUT,
  // Transmit parallel data toward serializer
  output logic [`PGC_DW-1:0] TX_DATA_OUT,
  // Receive parallel data and verifier status
  input wire logic [`PGC_DW-1:0] RX_DATA_IN,
  input wire logic CHECKER_MISMATCH_CLEAR_IN,
  output logic CHECKER_LOCK_FLAG_OUT,
  output logic CHECKER_MISMATCH_FLAG_OUT
);
  import pgc_pkg::*;

  // Register storage; only defined fields are kept
  logic [`PGC_SEED_W-1:0] seed_a_ff;
  logic [`PGC_SEED_W-1:0] seed_b_ff;
  logic [3:0] sqw_len_ff;
  logic [3:0] tx_poly_en_ff; // {p7, p23, p9, p31}
  logic tx_test_en_ff;
  logic tx_pat_sel_ff;
  logic data_sel_ff;
  logic tx_prbs_ce_ff;
  logic tx_sqw_ce_ff;
  logic [3:0] rx_poly_en_ff; // {p7, p23, p9, p31}
  logic rx_test_en_ff;
  logic rx_ce_ff;
  logic rx_kind_ff;

  // Generator and checker state
  logic [30:0] prbs_ff;
  logic [`PGC_SEED_W-1:0] scr_ff;
  logic [`PGC_RESEED_CNT_W-1:0] reseed_cnt_ff;
  logic use_b_ff;
  logic prp_run_ff;
  logic sqw_level_ff;
  logic [3:0] sqw_cnt_ff;
  logic [30:0] hist_ff;
  logic [4:0] clean_cnt_ff;
  pgc_chk_state_t chk_state_ff;
  logic lock_ff;
  logic mismatch_ff;
  logic [`PGC_DW-1:0] tx_data_ff;
  logic [`PGC_DW-1:0] wb_dat_ff;
  logic wb_ack_ff;

  // Bus decode
  logic wb_req;
  logic wb_wr;
  logic [`PGC_DW-1:0] rd_data;
  logic [15:0] wr16;
  logic [15:0] wmask;

  assign wb_req = WB_REQ_IN.cyc & WB_REQ_IN.stb & ~wb_ack_ff;
  assign wb_wr = wb_req & WB_REQ_IN.we;
  assign wr16 = WB_REQ_IN.dat[15:0];
  assign wmask = {{8{WB_REQ_IN.sel[1]}}, {8{WB_REQ_IN.sel[0]}}};

  // Byte-lane merge of a 16-bit register
  function automatic logic [15:0] merge16(input logic [15:0] old_v,
                                          input logic [15:0] new_v,
                                          input logic [15:0] m);
    merge16 = (old_v & ~m) | (new_v & m);
  endfunction : merge16

  // One-hot enables to polynomial; lowest bit number loses ties
  function automatic pgc_poly_t poly_of(input logic [3:0] en);
    if (en[3]) begin
      poly_of = POLY_7;
    end else if (en[2]) begin
      poly_of = POLY_23;
    end else if (en[1]) begin
      poly_of = POLY_9;
    end else if (en[0]) begin
      poly_of = POLY_31;
    end else begin
      poly_of = POLY_NONE;
    end
  endfunction : poly_of

  // Register taps: {length-1, second tap-1}
  function automatic logic [9:0] taps_of(input pgc_poly_t p);
    unique case (p)
      POLY_7: taps_of = {5'h06, 5'h05};
      POLY_9: taps_of = {5'h08, 5'h04};
      POLY_23: taps_of = {5'h16, 5'h11};
      POLY_31: taps_of = {5'h1e, 5'h1b};
      POLY_NONE: taps_of = {5'h06, 5'h05};
    endcase
  endfunction : taps_of

  // Legal square-wave run lengths
  function automatic logic sqw_legal(input logic [3:0] n);
    sqw_legal = (n == 4'h1) || (n == 4'h4) || (n == 4'h5) ||
                (n == 4'h6) || (n == 4'h8) || (n == 4'ha);
  endfunction : sqw_legal

  // Read-back; reserved bits read zero
  always_comb begin
    rd_data = '0;
    unique case (WB_REQ_IN.adr)
      `PGC_IDX_SEED_A0: rd_data[15:0] = seed_a_ff[15:0];
      `PGC_IDX_SEED_A1: rd_data[15:0] = seed_a_ff[31:16];
      `PGC_IDX_SEED_A2: rd_data[15:0] = seed_a_ff[47:32];
      `PGC_IDX_SEED_A3: rd_data[9:0] = seed_a_ff[57:48];
      `PGC_IDX_SEED_B0: rd_data[15:0] = seed_b_ff[15:0];
      `PGC_IDX_SEED_B1: rd_data[15:0] = seed_b_ff[31:16];
      `PGC_IDX_SEED_B2: rd_data[15:0] = seed_b_ff[47:32];
      `PGC_IDX_SEED_B3: rd_data[9:0] = seed_b_ff[57:48];
      `PGC_IDX_TX_CTRL: begin
        rd_data[`PGC_TX_SQW_MSB:`PGC_TX_SQW_LSB] = sqw_len_ff;
        rd_data[`PGC_TX_P7_BIT] = tx_poly_en_ff[3];
        rd_data[`PGC_TX_P23_BIT] = tx_poly_en_ff[2];
        rd_data[`PGC_TX_P9_BIT] = tx_poly_en_ff[1];
        rd_data[`PGC_TX_P31_BIT] = tx_poly_en_ff[0];
        rd_data[`PGC_TX_TEST_BIT] = tx_test_en_ff;
        rd_data[`PGC_TX_PSEL_BIT] = tx_pat_sel_ff;
        rd_data[`PGC_TX_DSEL_BIT] = data_sel_ff;
      end
      `PGC_IDX_TX_GATE: begin
        rd_data[`PGC_TX_PRBS_CE_BIT] = tx_prbs_ce_ff;
        rd_data[`PGC_TX_SQW_CE_BIT] = tx_sqw_ce_ff;
      end
      `PGC_IDX_RX_CTRL: begin
        rd_data[`PGC_RX_P7_BIT:`PGC_RX_P31_BIT] = rx_poly_en_ff;
        rd_data[`PGC_RX_TEST_BIT] = rx_test_en_ff;
      end
      `PGC_IDX_RX_GATE: rd_data[`PGC_RX_CE_BIT] = rx_ce_ff;
      `PGC_IDX_RX_KIND: rd_data[`PGC_RX_KIND_BIT] = rx_kind_ff;
      default: rd_data = '0; // Unmapped reads zero, still acked
    endcase
  end

  // Bus answer: ack one cycle after the request is seen
  always_ff @(posedge CORE_CLK_IN) begin
    if (RESET_IN) begin
      wb_ack_ff <= 1'b0;
      wb_dat_ff <= '0;
    end else if (CLK_EN_IN) begin
      wb_ack_ff <= wb_req;
      if (wb_req) begin
        wb_dat_ff <= rd_data;
      end
    end
  end

  // Seed registers, 16-bit words with byte lanes
  always_ff @(posedge CORE_CLK_IN) begin
    if (RESET_IN) begin
      seed_a_ff <= `PGC_RST_SEED_A;
      seed_b_ff <= `PGC_RST_SEED_B;
    end else if (CLK_EN_IN && wb_wr) begin
      unique case (WB_REQ_IN.adr)
        `PGC_IDX_SEED_A0:
          seed_a_ff[15:0] <= merge16(seed_a_ff[15:0], wr16, wmask);
        `PGC_IDX_SEED_A1:
          seed_a_ff[31:16] <= merge16(seed_a_ff[31:16], wr16, wmask);
        `PGC_IDX_SEED_A2:
          seed_a_ff[47:32] <= merge16(seed_a_ff[47:32], wr16, wmask);
        `PGC_IDX_SEED_A3:
          seed_a_ff[57:48] <= (seed_a_ff[57:48] & ~wmask[9:0]) |
                              (wr16[9:0] & wmask[9:0]);
        `PGC_IDX_SEED_B0:
          seed_b_ff[15:0] <= merge16(seed_b_ff[15:0], wr16, wmask);
        `PGC_IDX_SEED_B1:
          seed_b_ff[31:16] <= merge16(seed_b_ff[31:16], wr16, wmask);
        `PGC_IDX_SEED_B2:
          seed_b_ff[47:32] <= merge16(seed_b_ff[47:32], wr16, wmask);
        `PGC_IDX_SEED_B3:
          seed_b_ff[57:48] <= (seed_b_ff[57:48] & ~wmask[9:0]) |
                              (wr16[9:0] & wmask[9:0]);
        default: ;
      endcase
    end
  end

  // Control registers; unassigned bits are simply not stored
  always_ff @(posedge CORE_CLK_IN) begin
    if (RESET_IN) begin
      sqw_len_ff <= `PGC_RST_SQW;
      tx_poly_en_ff <= 4'h0;
      tx_test_en_ff <= 1'b0;
      tx_pat_sel_ff <= 1'b0;
      data_sel_ff <= 1'b0;
      tx_prbs_ce_ff <= 1'b0;
      tx_sqw_ce_ff <= 1'b0;
      rx_poly_en_ff <= 4'h0;
      rx_test_en_ff <= 1'b0;
      rx_ce_ff <= 1'b0;
      rx_kind_ff <= 1'b0;
    end else if (CLK_EN_IN && wb_wr) begin
      unique case (WB_REQ_IN.adr)
        `PGC_IDX_TX_CTRL: begin
          if (WB_REQ_IN.sel[1]) begin
            sqw_len_ff <= wr16[`PGC_TX_SQW_MSB:`PGC_TX_SQW_LSB];
            tx_poly_en_ff[3] <= wr16[`PGC_TX_P7_BIT];
            tx_poly_en_ff[2] <= wr16[`PGC_TX_P23_BIT];
          end
          if (WB_REQ_IN.sel[0]) begin
            tx_poly_en_ff[1] <= wr16[`PGC_TX_P9_BIT];
            tx_poly_en_ff[0] <= wr16[`PGC_TX_P31_BIT];
            tx_test_en_ff <= wr16[`PGC_TX_TEST_BIT];
            tx_pat_sel_ff <= wr16[`PGC_TX_PSEL_BIT];
            data_sel_ff <= wr16[`PGC_TX_DSEL_BIT];
          end
        end
        `PGC_IDX_TX_GATE: begin
          if (WB_REQ_IN.sel[0]) begin
            tx_prbs_ce_ff <= wr16[`PGC_TX_PRBS_CE_BIT];
            tx_sqw_ce_ff <= wr16[`PGC_TX_SQW_CE_BIT];
          end
        end
        `PGC_IDX_RX_CTRL: begin
          if (WB_REQ_IN.sel[1]) begin
            rx_poly_en_ff <= wr16[`PGC_RX_P7_BIT:`PGC_RX_P31_BIT];
            rx_test_en_ff <= wr16[`PGC_RX_TEST_BIT];
          end
        end
        `PGC_IDX_RX_GATE: begin
          if (WB_REQ_IN.sel[1]) begin
            rx_ce_ff <= wr16[`PGC_RX_CE_BIT];
          end
        end
        `PGC_IDX_RX_KIND: begin
          if (WB_REQ_IN.sel[0]) begin
            rx_kind_ff <= wr16[`PGC_RX_KIND_BIT];
          end
        end
        default: ;
      endcase
    end
  end

  // Transmit and receive mode decode
  pgc_poly_t tx_poly;
  pgc_poly_t rx_poly;
  logic [9:0] tx_taps;
  logic [9:0] rx_taps;
  logic sqw_mode;
  logic prbs_mode;
  logic prp_mode;
  logic prbs_step;
  logic sqw_step;
  logic rx_run;

  assign tx_poly = poly_of(tx_poly_en_ff);
  assign rx_poly = poly_of(rx_poly_en_ff);
  assign tx_taps = taps_of(tx_poly);
  assign rx_taps = taps_of(rx_poly);
  assign sqw_mode = tx_test_en_ff & tx_pat_sel_ff;
  assign prbs_mode = tx_test_en_ff & ~tx_pat_sel_ff &
                     (tx_poly != POLY_NONE);
  assign prp_mode = tx_test_en_ff & ~tx_pat_sel_ff &
                    (tx_poly == POLY_NONE);
  assign prbs_step = prbs_mode & tx_prbs_ce_ff;
  assign sqw_step = sqw_mode & tx_sqw_ce_ff & sqw_legal(sqw_len_ff);
  // Square mode on receive has no checker at all
  assign rx_run = rx_test_en_ff & rx_ce_ff & ~rx_kind_ff &
                  (rx_poly != POLY_NONE);

  // Next words of each generator, bit 0 first in time
  logic [30:0] nxt_prbs;
  logic [`PGC_DW-1:0] prbs_word;
  logic [`PGC_SEED_W-1:0] nxt_scr;
  logic [`PGC_SEED_W-1:0] scr_base;
  logic [`PGC_DW-1:0] prp_word;
  logic [`PGC_DW-1:0] prp_data;
  logic nxt_sqw_level;
  logic [3:0] nxt_sqw_cnt;
  logic [`PGC_DW-1:0] sqw_word;

  always_comb begin
    logic [30:0] s;
    logic b;
    b = 1'b0;
    s = (prbs_ff == '0) ? '1 : prbs_ff; // Escape the all-zero lockup
    prbs_word = '0;
    for (int i = 0; i < `PGC_DW; i++) begin
      b = s[tx_taps[9:5]] ^ s[tx_taps[4:0]];
      s = {s[29:0], b};
      prbs_word[i] = ~b;
    end
    nxt_prbs = s;
  end

  // Self-synchronising 58-bit scrambler over the data pattern
  always_comb begin
    logic [`PGC_SEED_W-1:0] s;
    logic b;
    s = '0;
    b = 1'b0;
    prp_data = data_sel_ff ? `PGC_LF_WORD : '0;
    scr_base = scr_ff;
    if (!prp_run_ff || (reseed_cnt_ff == '0)) begin
      scr_base = use_b_ff ? seed_b_ff : seed_a_ff;
    end
    s = scr_base;
    prp_word = '0;
    for (int i = 0; i < `PGC_DW; i++) begin
      b = prp_data[i] ^ s[`PGC_SCR_TAP_A] ^ s[`PGC_SCR_TAP_B];
      s = {s[`PGC_SEED_W-2:0], b};
      prp_word[i] = b;
    end
    nxt_scr = s;
  end

  // Square wave: equal runs of ones and zeros
  always_comb begin
    logic lvl;
    logic [3:0] cnt;
    lvl = sqw_level_ff;
    cnt = sqw_cnt_ff;
    sqw_word = '0;
    for (int i = 0; i < `PGC_DW; i++) begin
      sqw_word[i] = lvl;
      cnt = cnt + 4'h1;
      if (cnt >= sqw_len_ff) begin
        cnt = 4'h0;
        lvl = ~lvl;
      end
    end
    nxt_sqw_level = lvl;
    nxt_sqw_cnt = cnt;
  end

  // PRBS generator state, frozen while its clock gate is off
  always_ff @(posedge CORE_CLK_IN) begin
    if (RESET_IN) begin
      prbs_ff <= '1;
    end else if (CLK_EN_IN && prbs_step) begin
      prbs_ff <= nxt_prbs;
    end
  end

  // Pseudo-random pattern runs on every enabled cycle, no gate
  always_ff @(posedge CORE_CLK_IN) begin
    if (RESET_IN) begin
      scr_ff <= '0;
      reseed_cnt_ff <= '0;
      use_b_ff <= 1'b0;
      prp_run_ff <= 1'b0;
    end else if (CLK_EN_IN) begin
      prp_run_ff <= prp_mode;
      if (prp_mode) begin
        scr_ff <= nxt_scr;
        reseed_cnt_ff <= reseed_cnt_ff + 7'h01;
        if (reseed_cnt_ff == '1) begin
          use_b_ff <= ~use_b_ff; // Alternate seeds each period
        end
      end else begin
        reseed_cnt_ff <= '0;
        use_b_ff <= 1'b0;
      end
    end
  end

  // Square wave state; illegal length holds it still
  always_ff @(posedge CORE_CLK_IN) begin
    if (RESET_IN) begin
      sqw_level_ff <= 1'b1;
      sqw_cnt_ff <= 4'h0;
    end else if (CLK_EN_IN) begin
      if (!sqw_mode) begin
        sqw_level_ff <= 1'b1;
        sqw_cnt_ff <= 4'h0;
      end else if (sqw_step) begin
        sqw_level_ff <= nxt_sqw_level;
        sqw_cnt_ff <= nxt_sqw_cnt;
      end
    end
  end

  // Transmit output word; a gated generator holds its last word
  always_ff @(posedge CORE_CLK_IN) begin
    if (RESET_IN) begin
      tx_data_ff <= '0;
    end else if (CLK_EN_IN) begin
      if (!tx_test_en_ff) begin
        tx_data_ff <= '0;
      end else if (sqw_step) begin
        tx_data_ff <= sqw_word;
      end else if (prbs_step) begin
        tx_data_ff <= prbs_word;
      end else if (prp_mode) begin
        tx_data_ff <= prp_word;
      end else if (sqw_mode && !sqw_legal(sqw_len_ff)) begin
        tx_data_ff <= '0;
      end
    end
  end

  // Verifier: predict each bit from the inverted history
  logic [30:0] nxt_hist;
  logic word_err;

  always_comb begin
    logic [30:0] h;
    logic b;
    b = 1'b0;
    h = hist_ff;
    word_err = 1'b0;
    for (int i = 0; i < `PGC_DW; i++) begin
      b = ~RX_DATA_IN[i];
      if (b != (h[rx_taps[9:5]] ^ h[rx_taps[4:0]])) begin
        word_err = 1'b1;
      end
      h = {h[29:0], b};
    end
    nxt_hist = h;
  end

  // Lock after a run of clean words; errors after lock are sticky
  always_ff @(posedge CORE_CLK_IN) begin
    if (RESET_IN) begin
      hist_ff <= '0;
      clean_cnt_ff <= '0;
      chk_state_ff <= CHK_HUNT;
      lock_ff <= 1'b0;
    end else if (CLK_EN_IN) begin
      if (!rx_run) begin
        clean_cnt_ff <= '0;
        chk_state_ff <= CHK_HUNT;
        lock_ff <= 1'b0;
      end else begin
        hist_ff <= nxt_hist;
        unique case (chk_state_ff)
          CHK_HUNT: begin
            if (word_err) begin
              clean_cnt_ff <= '0;
            end else if (clean_cnt_ff == `PGC_LOCK_WORDS - 5'h1) begin
              chk_state_ff <= CHK_LOCKED;
              lock_ff <= 1'b1;
            end else begin
              clean_cnt_ff <= clean_cnt_ff + 5'h1;
            end
          end
          CHK_LOCKED: lock_ff <= 1'b1;
        endcase
      end
    end
  end

  // Sticky mismatch; a new error wins over a same-cycle clear
  always_ff @(posedge CORE_CLK_IN) begin
    if (RESET_IN) begin
      mismatch_ff <= 1'b0;
    end else if (CLK_EN_IN) begin
      if (rx_run && chk_state_ff == CHK_LOCKED && word_err) begin
        mismatch_ff <= 1'b1;
      end else if (CHECKER_MISMATCH_CLEAR_IN) begin
        mismatch_ff <= 1'b0;
      end
    end
  end

  // Outputs straight from flops
  assign WB_DAT_OUT = wb_dat_ff;
  assign WB_ACK_OUT = wb_ack_ff;
  assign TX_DATA_OUT = tx_data_ff;
  assign CHECKER_LOCK_FLAG_OUT = lock_ff;
  assign CHECKER_MISMATCH_FLAG_OUT = mismatch_ff;

endmodule : pgc_top

// File: testbench/pgc_checker.sv
`timescale 1ns/1ps
`include "pgc_cfg.svh"
module pgc_checker (
  // Clock, reset, enable
  input wire logic CORE_CLK_IN,
  input wire logic RESET_IN,
  input wire logic CLK_EN_IN,
  // Register bus
  input wire pgc_pkg::pgc_wb_req_t WB_REQ_IN,
  input wire logic [`PGC_DW-1:0] WB_DAT_OUT,
  input wire logic WB_ACK_OUT,
  // Pattern streams and verifier status
  input wire logic [`PGC_DW-1:0] TX_DATA_OUT,
  input wire logic [`PGC_DW-1:0] RX_DATA_IN,
  input wire logic CHECKER_MISMATCH_CLEAR_IN,
  input wire logic CHECKER_LOCK_FLAG_OUT,
  input wire logic CHECKER_MISMATCH_FLAG_OUT
);
  import pgc_pkg::*;
  default clocking cb @(posedge CORE_CLK_IN); endclocking
  default disable iff (RESET_IN);

  // Request accepted by the slave, and a read of one index
  sequence s_take;
    WB_REQ_IN.cyc && WB_REQ_IN.stb && !WB_ACK_OUT && CLK_EN_IN;
  endsequence
  sequence s_read(idx);
    s_take ##0 (!WB_REQ_IN.we && WB_REQ_IN.adr == idx);
  endsequence

  a_ack_answer: assert property (s_take |=> WB_ACK_OUT)
    else $error("no ack after accepted request");
  a_ack_pulse: assert property (
    WB_ACK_OUT && CLK_EN_IN |=> !WB_ACK_OUT)
    else $error("ack longer than one cycle");
  a_ack_cause: assert property (
    !(WB_REQ_IN.cyc && WB_REQ_IN.stb) && CLK_EN_IN |=> !WB_ACK_OUT)
    else $error("ack without request");
  a_unmapped_zero: assert property (
    s_read(10'h136) |=> WB_DAT_OUT == 32'h0)
    else $error("unmapped read not zero");
  a_reserved_zero: assert property (
    s_read(`PGC_IDX_SEED_A3) |=> WB_DAT_OUT[31:10] == 22'h0)
    else $error("reserved seed bits not zero");
  a_reset_quiet: assert property ($past(RESET_IN) |->
    !WB_ACK_OUT && TX_DATA_OUT == 32'h0 && !CHECKER_LOCK_FLAG_OUT
    && !CHECKER_MISMATCH_FLAG_OUT)
    else $error("outputs active after reset");
  a_mm_sticky: assert property (CHECKER_MISMATCH_FLAG_OUT &&
    !CHECKER_MISMATCH_CLEAR_IN |=> CHECKER_MISMATCH_FLAG_OUT)
    else $error("mismatch dropped without clear");
  a_mm_locked: assert property ($rose(CHECKER_MISMATCH_FLAG_OUT)
    |-> $past(CHECKER_LOCK_FLAG_OUT))
    else $error("mismatch flagged before lock");
  a_mm_clear: assert property ($fell(CHECKER_MISMATCH_FLAG_OUT)
    |-> $past(CHECKER_MISMATCH_CLEAR_IN) || $past(RESET_IN))
    else $error("mismatch fell without clear");
  a_lock_hunt: assert property ($rose(CHECKER_LOCK_FLAG_OUT)
    |-> $past(CHECKER_LOCK_FLAG_OUT, 16) == 1'b0)
    else $error("lock rose too early");
endmodule : pgc_checker

bind pgc_top pgc_checker u_pgc_checker (.CORE_CLK_IN, .RESET_IN,
  .CLK_EN_IN, .WB_REQ_IN, .WB_DAT_OUT, .WB_ACK_OUT, .TX_DATA_OUT,
  .RX_DATA_IN, .CHECKER_MISMATCH_CLEAR_IN, .CHECKER_LOCK_FLAG_OUT,
  .CHECKER_MISMATCH_FLAG_OUT);

// File: testbench/pgc_link_model.sv
`timescale 1ns/1ps
`include "pgc_cfg.svh"
module pgc_link_model (
  // Clock and far-end behaviour
  input wire logic clk_in,
  input wire logic slow_in,
  input wire logic err_in,
  // Serializer word in, looped-back word out
  input wire logic [`PGC_DW-1:0] tx_in,
  output logic [`PGC_DW-1:0] rx_out
);
  logic [`PGC_DW-1:0] dly_ff;

  // One word of extra line delay for the slow far end
  always_ff @(posedge clk_in) begin
    dly_ff <= tx_in;
  end

  // Pattern returned as sent, inverted form kept
  // A commanded fault flips the earliest bit only
  assign rx_out = (slow_in ? dly_ff : tx_in) ^ {31'h0, err_in};
endmodule : pgc_link_model

// File: testbench/tb.sv
`timescale 1ns/1ps
`include "pgc_cfg.svh"
module tb;
  import pgc_pkg::*;
  // Stimulus and observed signals
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic ce = 1'b1;
  logic clr = 1'b0;
  logic slow = 1'b0;
  logic err = 1'b0;
  pgc_wb_req_t req = '0;
  logic [31:0] rdat;
  logic [31:0] rxd;
  logic [31:0] txd;
  logic ack;
  logic lk;
  logic mm;
  int bad_count = 0;
  int n_tests = 0;
  int cyc_n = 0;

  // 250 MHz clock
  always #2 clk = ~clk;

  pgc_top u_pgc_top (.CORE_CLK_IN(clk), .RESET_IN(rst), .CLK_EN_IN(ce),
    .WB_REQ_IN(req), .WB_DAT_OUT(rdat), .WB_ACK_OUT(ack),
    .TX_DATA_OUT(txd), .RX_DATA_IN(rxd), .CHECKER_MISMATCH_CLEAR_IN(clr),
    .CHECKER_LOCK_FLAG_OUT(lk), .CHECKER_MISMATCH_FLAG_OUT(mm));
  pgc_link_model u_pgc_link_model (.clk_in(clk), .slow_in(slow),
    .err_in(err), .tx_in(txd), .rx_out(rxd));

  // Hang guard; the run needs well under a thousand cycles
  always @(posedge clk) begin
    cyc_n <= cyc_n + 1;
    if (cyc_n == 20000) begin
      bad_count++;
      conclude();
    end
  end

  task automatic conclude;
    $display("checks=%0d mismatches=%0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : conclude

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      bad_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  // One classic cycle; held until ack is sampled high
  task automatic wbx(input logic w, input logic [9:0] a,
                     input logic [31:0] d, output logic [31:0] q);
    int n;
    n = 0;
    req <= {2'b11, w, 4'hf, a, d};
    do begin
      @(posedge clk);
      n++;
    end while (ack !== 1'b1 && n < 50);
    chk({31'h0, ack}, 32'h1);
    q = rdat;
    req <= '0;
    @(posedge clk);
  endtask : wbx

  task automatic wr(input logic [9:0] a, input logic [31:0] d);
    logic [31:0] q;
    wbx(1'b1, a, d, q);
  endtask : wr

  task automatic rd(input logic [9:0] a, input logic [31:0] e);
    logic [31:0] q;
    wbx(1'b0, a, 32'h0, q);
    chk(q, e);
  endtask : rd

  task automatic grab(output logic [31:0] w);
    @(posedge clk);
    w = txd;
  endtask : grab

  task automatic wait_lk(input int lim);
    for (int i = 0; i < lim && lk !== 1'b1; i++) @(posedge clk);
  endtask : wait_lk

  // Next word of an inverted Fibonacci sequence, bit 0 first
  function automatic logic [31:0] prbs_word(input int n, input int m,
                                            inout logic [30:0] s);
    logic b;
    for (int i = 0; i < 32; i++) begin
      b = s[n-1] ^ s[m-1];
      s = {s[29:0], b};
      prbs_word[i] = ~b;
    end
  endfunction : prbs_word

  task automatic t_regs;
    logic [9:0] ix [9] = '{`PGC_IDX_SEED_A1, `PGC_IDX_SEED_A3,
      `PGC_IDX_SEED_B2, `PGC_IDX_SEED_B3, `PGC_IDX_TX_CTRL,
      `PGC_IDX_TX_GATE, `PGC_IDX_RX_CTRL, `PGC_IDX_RX_GATE,
      `PGC_IDX_RX_KIND};
    logic [31:0] mk [9] = '{32'hffff, 32'h3ff, 32'hffff, 32'h3ff,
      32'hf55b, 32'h6, 32'h7c00, 32'h400, 32'h1};
    rd(`PGC_IDX_SEED_A0, 32'haaaa);
    rd(`PGC_IDX_SEED_A3, 32'h2aa);
    rd(`PGC_IDX_SEED_B0, 32'h5555);
    rd(`PGC_IDX_SEED_B3, 32'h155);
    rd(`PGC_IDX_TX_CTRL, 32'h4000);
    wr(10'h136, 32'hffff_ffff);
    rd(10'h136, 32'h0);
    // All-ones write shows which bits are stored
    for (int i = 0; i < 9; i++) begin
      wr(ix[i], 32'hffff_ffff);
      rd(ix[i], mk[i]);
      wr(ix[i], 32'h0);
    end
    $display("test regs done");
  endtask : t_regs

  task automatic t_prbs;
    logic [15:0] tx_m [4] = '{16'h0408, 16'h0108, 16'h0048, 16'h0018};
    logic [15:0] rx_m [4] = '{16'h4400, 16'h2400, 16'h1400, 16'h0c00};
    int pn [4] = '{7, 23, 9, 31};
    int pm [4] = '{6, 18, 5, 28};
    logic [30:0] s;
    logic [31:0] w;
    logic [31:0] e;
    wr(`PGC_IDX_TX_GATE, 32'h4);
    wr(`PGC_IDX_RX_GATE, 32'h400);
    for (int i = 0; i < 4; i++) begin
      wr(`PGC_IDX_RX_CTRL, 32'h0);
      slow <= i[0];
      wr(`PGC_IDX_TX_CTRL, {16'h0, tx_m[i]});
      wr(`PGC_IDX_RX_CTRL, {16'h0, rx_m[i]});
      grab(w);
      for (int k = 0; k < 31; k++) s[k] = ~w[31-k];
      for (int j = 0; j < 3; j++) begin
        grab(w);
        e = prbs_word(pn[i], pm[i], s);
        chk(w, e);
      end
      wait_lk(60);
      chk({31'h0, lk}, 32'h1);
      chk({31'h0, mm}, 32'h0);
    end
    $display("test prbs done");
  endtask : t_prbs

  task automatic t_error;
    err <= 1'b1;
    @(posedge clk);
    err <= 1'b0;
    repeat (12) @(posedge clk);
    chk({31'h0, mm}, 32'h1);
    chk({31'h0, lk}, 32'h1);
    clr <= 1'b1;
    @(posedge clk);
    clr <= 1'b0;
    repeat (3) @(posedge clk);
    chk({31'h0, mm}, 32'h0);
    $display("test error done");
  endtask : t_error

  task automatic t_rx_off;
    logic [9:0] sa [3] = '{`PGC_IDX_RX_GATE, `PGC_IDX_RX_KIND,
      `PGC_IDX_RX_CTRL};
    logic [31:0] sd [3] = '{32'h0, 32'h1, 32'h800};
    for (int i = 0; i < 3; i++) begin
      wr(`PGC_IDX_RX_CTRL, 32'h0);
      wr(`PGC_IDX_RX_GATE, 32'h400);
      wr(`PGC_IDX_RX_KIND, 32'h0);
      wr(`PGC_IDX_RX_CTRL, 32'hc00);
      wait_lk(60);
      chk({31'h0, lk}, 32'h1);
      wr(sa[i], sd[i]);
      repeat (5) @(posedge clk);
      chk({31'h0, lk}, 32'h0);
    end
    $display("test rx stop done");
  endtask : t_rx_off

  task automatic t_gate;
    logic [31:0] a;
    logic [31:0] b;
    wr(`PGC_IDX_TX_GATE, 32'h0);
    grab(a);
    grab(b);
    chk(b, a);
    wr(`PGC_IDX_TX_GATE, 32'h4);
    ce <= 1'b0;
    grab(a);
    grab(b);
    ce <= 1'b1;
    chk(b, a);
    $display("test gate done");
  endtask : t_gate

  task automatic t_square;
    logic [3:0] ln [7] = '{4'd1, 4'd4, 4'd5, 4'd6, 4'd8, 4'd10, 4'd2};
    logic [95:0] v;
    int bad;
    wr(`PGC_IDX_TX_GATE, 32'h2);
    for (int i = 0; i < 7; i++) begin
      wr(`PGC_IDX_TX_CTRL, {16'h0, ln[i], 12'h00a});
      repeat (4) @(posedge clk);
      for (int j = 0; j < 3; j++) grab(v[32*j +: 32]);
      bad = 0;
      for (int k = 0; k < 96 - ln[i]; k++) bad += (v[k+ln[i]] === v[k]);
      if (i == 6)
        chk(v[31:0] | v[63:32] | v[95:64], 32'h0);
      else
        chk(32'(bad), 32'h0);
    end
    $display("test square done");
  endtask : t_square

  task automatic t_prp;
    logic [31:0] a;
    logic [31:0] b;
    for (int i = 0; i < 8; i++) wr(`PGC_IDX_SEED_A0 + 10'(i), 32'h0);
    wr(`PGC_IDX_TX_GATE, 32'h0);
    wr(`PGC_IDX_TX_CTRL, 32'h8);
    grab(a);
    chk(a, 32'h0);
    wr(`PGC_IDX_TX_CTRL, 32'h9);
    grab(a);
    grab(b);
    chk({31'h0, a !== b}, 32'h1);
    chk({31'h0, a !== 32'h0}, 32'h1);
    wr(`PGC_IDX_TX_CTRL, 32'h1);
    grab(a);
    chk(a, 32'h0);
    $display("test random pattern done");
  endtask : t_prp

  // Main sequence
  initial begin
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    t_regs();
    t_prbs();
    t_error();
    t_rx_off();
    t_gate();
    t_square();
    t_prp();
    conclude();
  end
endmodule : tb
